// ==== hw/tsi_pkg.sv ====
// Shared constants and types for the temperature sensor two-wire link
package tsi_pkg;
    // System clock rate
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;
    // Settle time after power-up before bus commands are heard
    localparam int POR_MS = 20;
    localparam int POR_CYC = POR_MS * CLK_PER_MS;
    // Stuck-line timeout window; the least figure sets the count
    localparam int TOUT_MIN_MS = 15;
    localparam int TOUT_MAX_MS = 45;
    localparam int TOUT_CYC = TOUT_MIN_MS * CLK_PER_MS;
    // Length of one conversion, in cycles
    localparam int CONV_CYC = 2000;
    localparam int CNT_W = 20;
    // Controller quarter bit period, 400 kHz bus clock
    localparam int QTR_NS = 625;
    localparam int QTR_CYC = (QTR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int QTR_W = 4;
    // Temperature: 12-bit two's complement, 0.0625 C per step
    localparam int TEMP_W = 12;
    localparam logic [TEMP_W-1:0] TEMP_RST = 12'h000;
    // Target address: fixed upper five bits, strap picks the low two
    localparam logic [4:0] ADDR_BASE = 5'h12;
    localparam logic [7:0] GC_BYTE = 8'h00;
    localparam logic [7:0] ARA_BYTE = 8'h19;
    localparam logic [4:0] HS_PREFIX = 5'h01;
    localparam logic [7:0] GC_LATCH = 8'h04;
    localparam logic [7:0] GC_RESET = 8'h06;
    // Controller register offsets
    localparam logic [3:0] HR_CMD = 4'h0;
    localparam logic [3:0] HR_TXD = 4'h4;
    localparam logic [3:0] HR_STAT = 4'h8;
    localparam logic [3:0] HR_RXD = 4'hc;
    // Target link states
    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_RXB = 3'b001,
        DS_RACK = 3'b010,
        DS_TXB = 3'b011,
        DS_TACK = 3'b100
    } tsi_dst_t;
    // Controller operations
    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_STOP = 2'b11
    } tsi_op_t;
    // Conversion modes
    typedef enum logic [1:0] {
        CM_SHDN = 2'b00,
        CM_ONESHOT = 2'b01,
        CM_CONT = 2'b10,
        CM_RSVD = 2'b11
    } tsi_cmode_t;
endpackage : tsi_pkg

// ==== hw/tsi_if.sv ====
// Two-wire link carrier between bus controller and sensor target
`timescale 1ns/10ps
`default_nettype none
interface tsi_if;
    logic scl_oe; // Controller pulls clock low
    logic sda_host_oe; // Controller pulls data low
    logic sda_dev_oe; // Target pulls data low
    logic alert_oe; // Target pulls alert low
    logic scl; // Resolved clock level
    logic sda; // Resolved data level
    logic alert_n; // Resolved alert level

    // Open-drain wires with pull-ups
    assign scl = ~scl_oe;
    assign sda = ~(sda_host_oe | sda_dev_oe);
    assign alert_n = ~alert_oe;

    modport dev (input scl, input sda, output sda_dev_oe, output alert_oe);
    modport host (input sda, input alert_n, output scl_oe,
        output sda_host_oe);
endinterface : tsi_if
`default_nettype wire

// ==== hw/tsi_dev.sv ====
// Sensor end: two-wire target, conversion control and alert
//
// Behaviour
// (RULE1) Temperature kept as 12-bit two's complement
// (RULE2) Temperature readable at any time
// (RULE3) Reading never disturbs a running conversion
// (RULE4) Two mode bits pick one-shot, continuous, shutdown
// (RULE5) Controller makes clock, moves all data
// (RULE6) First byte: seven address bits, one direction
// (RULE7) Strap pin picks one of four addresses
// (RULE8) Bus ignored for 20 ms after power-up
// (RULE9) Strap latched at first START, then held
// (RULE10) Alert only in interrupt mode
// (RULE11) Controller answers alert with response byte
// (RULE12) Alerting target acks response, sends address
// (RULE13) Address LSB: 1 above high, 0 below low
// (RULE14) Losing arbitration keeps alert asserted
// (RULE15) General call acked, next byte obeyed
// (RULE16) General call 04 relatches strap
// (RULE17) General call 06 resets registers
// (RULE18) High-speed code 00001xxx opens fast mode
// (RULE19) After high-speed code, up to 3.4 MHz
// (RULE20) Line low past timeout: release, go idle
// (RULE21) One-shot converts once then shuts down
// (RULE22) Unknown addresses are not acknowledged
`timescale 1ns/10ps
`default_nettype none
module tsi_dev
    import tsi_pkg::*;
#(
    parameter int POR_LEN = POR_CYC, // Power-up settle, cycles
    parameter int TOUT_LEN = TOUT_CYC // Stuck-line timeout, cycles
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    tsi_if.dev bus, // Two-wire link
    input wire logic [1:0] addr_select_pin, // Strap: gnd,vcc,data,clock
    input wire logic conv_mode_hi_bit, // Mode field, upper bit
    input wire logic conv_mode_lo_bit, // Mode field, lower bit
    input wire logic comparator_interrupt_select, // 1 selects interrupt
    input wire logic oneshot_req, // One-shot trigger pulse
    input wire logic [TEMP_W-1:0] adc_code, // Converter result
    input wire logic [TEMP_W-1:0] limit_high, // Upper limit
    input wire logic [TEMP_W-1:0] limit_low, // Lower limit
    output logic [TEMP_W-1:0] temp_value, // Temperature register
    output logic conv_busy, // Conversion running
    output logic hs_active, // High-speed code seen
    output logic [6:0] own_address, // Latched target address
    output logic bus_ready // Power-up settle over
);
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        tsi_dst_t st;
        logic [3:0] cnt;
        logic [7:0] sr;
        logic is_addr;
        logic gc;
        logic ara;
        logic nxt_tx;
        logic idx;
        logic hs;
        logic latched;
        logic [6:0] own;
        logic [TEMP_W-1:0] temp;
        logic [TEMP_W-1:0] snap;
        logic alert;
        logic over;
        logic busy;
        logic sda_oe;
        logic [CNT_W-1:0] conv_cnt;
        logic [CNT_W-1:0] tout_cnt;
        logic [CNT_W-1:0] por_cnt;
        logic ready;
    } tsi_dreg_t;

    tsi_dreg_t q;
    tsi_dreg_t n;
    logic scl_h;
    logic sda_h;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Strap code to target address
    function automatic logic [6:0] addr_of(input logic [1:0] code);
        return {ADDR_BASE, code}; // RULE7
    endfunction : addr_of

    // Next byte to send: alert answer or temperature halves
    function automatic logic [7:0] tx_byte(input logic ara,
        input logic idx, input logic [6:0] own, input logic over,
        input logic [TEMP_W-1:0] t);
        if (ara) begin
            return {own, over}; // RULE13
        end
        if (idx) begin
            return {t[3:0], 4'h0};
        end
        return t[11:4];
    endfunction : tx_byte

    ////////////////////////////////////////////////////////////////////
    // Line events, read only from second sync stage onward
    assign scl_h = q.scl_s[1];
    assign sda_h = q.sda_s[1];
    assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
    assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
    assign start_ev = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
    assign stop_ev = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic ack;
        logic soft_rst;
        logic [7:0] b;
        tsi_cmode_t mode;
        ack = 1'b0;
        soft_rst = 1'b0;
        b = 8'h00;
        mode = tsi_cmode_t'({conv_mode_hi_bit, conv_mode_lo_bit}); // RULE4
        n = q;
        n.scl_s = {q.scl_s[1:0], bus.scl};
        n.sda_s = {q.sda_s[1:0], bus.sda};
        n.pin_s1 = addr_select_pin;
        n.pin_s2 = q.pin_s1;
        // Power-up settle; bus deaf until it ends
        if (!q.ready) begin
            n.por_cnt = q.por_cnt + 1'b1;
            n.ready = (q.por_cnt == CNT_W'(POR_LEN - 1)); // RULE8
        end
        // Either line low while busy on the bus
        if (q.st != DS_IDLE && !(scl_h && sda_h)) begin
            n.tout_cnt = q.tout_cnt + 1'b1;
        end else begin
            n.tout_cnt = '0;
        end
        if (!q.ready) begin
            n.st = DS_IDLE; // RULE8
        end else if (start_ev) begin
            n.st = DS_RXB;
            n.cnt = 4'h0;
            n.is_addr = 1'b1; // RULE6
            n.gc = 1'b0;
            n.ara = 1'b0;
            n.sda_oe = 1'b0;
            if (!q.latched) begin
                n.own = addr_of(q.pin_s2); // RULE9
                n.latched = 1'b1; // RULE9
            end
        end else if (stop_ev) begin
            n.st = DS_IDLE;
            n.sda_oe = 1'b0;
            n.hs = 1'b0;
        end else begin
            unique case (q.st)
                DS_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                DS_RXB: begin
                    if (scl_rise && q.cnt != 4'h8) begin
                        n.sr = {q.sr[6:0], sda_h}; // RULE5
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == 4'h8) begin
                        ack = 1'b1;
                        n.nxt_tx = 1'b0;
                        n.idx = 1'b0;
                        if (q.is_addr) begin
                            if (q.sr[7:3] == HS_PREFIX) begin
                                // Master code is never acked
                                n.hs = 1'b1; // RULE19
                                ack = 1'b0;
                            end else if (q.sr[7:1] == q.own) begin
                                n.nxt_tx = q.sr[0]; // RULE6
                            end else if (q.sr == GC_BYTE) begin
                                n.gc = 1'b1; // RULE15
                            end else if (q.sr == ARA_BYTE && q.alert) begin
                                n.ara = 1'b1; // RULE12
                                n.nxt_tx = 1'b1;
                            end else begin
                                ack = 1'b0; // RULE22
                            end
                        end else if (q.gc && q.sr == GC_LATCH) begin
                            n.own = addr_of(q.pin_s2); // RULE16
                            n.latched = 1'b1;
                        end else if (q.gc && q.sr == GC_RESET) begin
                            soft_rst = 1'b1; // RULE17
                        end
                        n.is_addr = 1'b0;
                        n.sda_oe = ack;
                        n.st = ack ? DS_RACK : DS_IDLE;
                    end
                end
                DS_RACK: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (q.nxt_tx) begin
                            // Snapshot keeps both halves coherent
                            b = tx_byte(q.ara, q.idx, q.own, q.over,
                                q.idx ? q.snap : q.temp); // RULE2
                            if (!q.idx) begin
                                n.snap = q.temp;
                            end
                            n.idx = ~q.idx;
                            n.sr = b;
                            n.sda_oe = ~b[7];
                            n.st = DS_TXB;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st = DS_RXB;
                        end
                    end
                end
                DS_TXB: begin
                    if (scl_rise) begin
                        if (q.ara && !q.sda_oe && !sda_h) begin
                            // Lost: alert stays up for a later round
                            n.st = DS_IDLE; // RULE14
                        end else begin
                            n.cnt = q.cnt + 4'h1;
                        end
                    end else if (scl_fall) begin
                        if (q.cnt == 4'h8) begin
                            n.sda_oe = 1'b0;
                            n.st = DS_TACK;
                        end else begin
                            n.sr = {q.sr[6:0], 1'b0};
                            n.sda_oe = ~q.sr[6];
                        end
                    end
                end
                DS_TACK: begin
                    if (scl_rise) begin
                        if (q.ara) begin
                            n.alert = 1'b0; // RULE14
                            n.st = DS_IDLE;
                        end else if (sda_h) begin
                            n.st = DS_IDLE;
                        end else begin
                            n.nxt_tx = 1'b1;
                            n.st = DS_RACK;
                        end
                    end
                end
                default: begin
                    n.st = DS_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
        // Never hang the bus on a stuck line
        if (q.tout_cnt == CNT_W'(TOUT_LEN - 1)) begin
            n.st = DS_IDLE; // RULE20
            n.sda_oe = 1'b0; // RULE20
            n.tout_cnt = '0;
        end
        // Register reset by broadcast command
        if (soft_rst) begin
            n.temp = TEMP_RST; // RULE17
            n.alert = 1'b0;
            n.over = 1'b0;
            n.latched = 1'b0;
        end
        // Conversion runs apart from bus traffic; set beats clears above
        if (q.busy) begin
            n.conv_cnt = q.conv_cnt + 1'b1; // RULE3
            if (q.conv_cnt == CNT_W'(CONV_CYC - 1)) begin
                n.conv_cnt = '0;
                n.busy = (mode == CM_CONT); // RULE21
                n.temp = adc_code; // RULE1
                if (comparator_interrupt_select) begin
                    if ($signed(adc_code) > $signed(limit_high)) begin
                        n.alert = 1'b1; // RULE10
                        n.over = 1'b1; // RULE13
                    end else if ($signed(adc_code) < $signed(limit_low)) begin
                        n.alert = 1'b1; // RULE10
                        n.over = 1'b0; // RULE13
                    end
                end
            end
        end else if (mode == CM_CONT || (mode == CM_ONESHOT && oneshot_req)) begin
            n.busy = 1'b1; // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from state
    assign bus.sda_dev_oe = q.sda_oe;
    assign bus.alert_oe = q.alert;
    assign temp_value = q.temp;
    assign conv_busy = q.busy;
    assign hs_active = q.hs;
    assign own_address = q.own;
    assign bus_ready = q.ready;
endmodule : tsi_dev
`default_nettype wire

// ==== hw/tsi_host.sv ====
// Controller end: byte-level two-wire bus controller with register port
`timescale 1ns/10ps
`default_nettype none
module tsi_host
    import tsi_pkg::*;
#(
    parameter int POR_LEN = POR_CYC // Power-up wait, cycles
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    tsi_if.host bus, // Two-wire link
    input wire logic [3:0] addr, // Register byte address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata // Read data, cycle after strobe
);
    typedef struct packed {
        logic [1:0] sda_s;
        logic [1:0] alert_s;
        logic scl_oe;
        logic sda_oe;
        logic run;
        tsi_op_t op;
        logic ackr;
        logic [1:0] ph;
        logic [QTR_W-1:0] qcnt;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic nack;
        logic [7:0] rdata;
        logic [CNT_W-1:0] por_cnt;
        logic ready;
    } tsi_hreg_t;

    tsi_hreg_t q;
    tsi_hreg_t n;

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic last;
        last = 1'b0;
        n = q;
        n.sda_s = {q.sda_s[0], bus.sda};
        n.alert_s = {q.alert_s[0], ~bus.alert_n};
        // Sensor is deaf for its settle time, so wait it out
        if (!q.ready) begin
            n.por_cnt = q.por_cnt + 1'b1;
            n.ready = (q.por_cnt == CNT_W'(POR_LEN - 1)); // RULE8
        end
        // Register writes; commands while busy are dropped
        if (wr && addr == HR_TXD) begin
            n.txd = wdata;
        end
        if (wr && addr == HR_CMD && q.ready && !q.run) begin
            n.run = 1'b1;
            n.op = tsi_op_t'(wdata[1:0]);
            n.ackr = wdata[2];
            n.ph = 2'h0;
            n.cnt = 4'h0;
            n.qcnt = '0;
            n.sh = q.txd; // RULE6
            if (wdata[1:0] == OP_WRITE) begin
                n.nack = 1'b0;
            end
        end
        // Read answer, zero for unmapped offsets
        n.rdata = 8'h00;
        if (rd) begin
            if (addr == HR_STAT) begin
                n.rdata = {4'h0, q.ready, q.alert_s[1], q.nack, q.run};
            end else if (addr == HR_RXD) begin
                n.rdata = q.rxd;
            end else if (addr == HR_TXD) begin
                n.rdata = q.txd;
            end
        end
        // Bit engine, four quarter periods per bit; we make the clock
        last = (q.op == OP_START || q.op == OP_STOP || q.cnt == 4'h8);
        if (q.run) begin
            n.qcnt = q.qcnt + 1'b1;
            if (q.qcnt == QTR_W'(QTR_CYC - 1)) begin
                n.qcnt = '0;
                n.ph = q.ph + 2'h1;
                unique case (q.ph)
                    2'h0: begin
                        unique case (q.op)
                            OP_START: n.sda_oe = 1'b0;
                            OP_WRITE: n.sda_oe = (q.cnt != 4'h8) & ~q.sh[7];
                            OP_READ: n.sda_oe = (q.cnt == 4'h8) & q.ackr;
                            OP_STOP: n.sda_oe = 1'b1;
                        endcase
                    end
                    2'h1: begin
                        n.scl_oe = 1'b0; // RULE5
                    end
                    2'h2: begin
                        unique case (q.op)
                            OP_START: n.sda_oe = 1'b1; // RULE18
                            OP_WRITE: begin
                                if (q.cnt == 4'h8) begin
                                    n.nack = q.sda_s[1];
                                end
                            end
                            OP_READ: begin
                                if (q.cnt != 4'h8) begin
                                    n.sh = {q.sh[6:0], q.sda_s[1]};
                                end
                            end
                            OP_STOP: n.sda_oe = 1'b0;
                        endcase
                    end
                    2'h3: begin
                        n.scl_oe = (q.op != OP_STOP); // RULE5
                        n.cnt = q.cnt + 4'h1;
                        if (q.op == OP_WRITE) begin
                            n.sh = {q.sh[6:0], 1'b0};
                        end
                        if (last) begin
                            n.run = 1'b0;
                            if (q.op == OP_READ) begin
                                n.rxd = q.sh;
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from state
    assign bus.scl_oe = q.scl_oe;
    assign bus.sda_host_oe = q.sda_oe;
    assign rdata = q.rdata;
endmodule : tsi_host
`default_nettype wire

// ==== tb/tsi_link_properties.sv ====
// Link properties watched beside the controller-to-target interface
`timescale 1ns/10ps
`default_nettype none
module tsi_link_properties #(
    parameter int POR_LEN = 50, // Power-up settle, cycles
    parameter int TOUT_LEN = 600 // Stuck-line timeout, cycles
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic scl, // Resolved clock
    input wire logic sda, // Resolved data
    input wire logic sda_dev_oe, // Target pulls data
    input wire logic alert_oe // Target pulls alert
);
    int por_q;
    int low_q;

    // Cycles since reset, saturated at POR_LEN to stay small, and run of a low line, unsaturated
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            por_q <= 0;
            low_q <= 0;
        end else begin
            por_q <= (por_q < POR_LEN) ? por_q + 1 : por_q;
            low_q <= (scl && sda) ? 0 : low_q + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    dev_edge_a: assert property (
        $changed(sda_dev_oe) |-> !scl && !$past(scl))
        else $error("Target data moved with clock high");
    bit_hold_a: assert property (
        $rose(scl) |=> $stable(sda_dev_oe) [*8])
        else $error("Target bit not held after clock rise");
    por_quiet_a: assert property (
        por_q < POR_LEN |-> !sda_dev_oe)
        else $error("Target answered before settle time");
    rst_idle_a: assert property (
        $fell(srst) |-> !sda_dev_oe && !alert_oe)
        else $error("Target lines busy after reset");
    tout_rel_a: assert property (
        low_q > TOUT_LEN + 8 |-> !sda_dev_oe)
        else $error("Target kept data low past timeout");
    alert_clr_a: assert property (
        $fell(alert_oe) |-> scl)
        else $error("Alert cleared away from a clock rise");
    start_host_a: assert property (
        scl && $fell(sda) |-> !sda_dev_oe)
        else $error("Target formed a start");
    stop_quiet_a: assert property (
        scl && $rose(sda) |=> !sda_dev_oe [*4])
        else $error("Target drove data after stop");
endmodule : tsi_link_properties
`default_nettype wire

// ==== tb/tb_temp_sensor_i2c_target.sv ====
// Bench joining controller and sensor target over the two-wire link
`timescale 1ns/10ps
`default_nettype none
module tb_temp_sensor_i2c_target;
    import tsi_pkg::*;
    localparam int POR = 50;
    // Must outlast a general call: nine low bits, a pause, five more
    localparam int TOUT = 2000;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [1:0] strap = 2'h0;
    logic [1:0] mode = 2'h2;
    logic tm = 1'b0;
    logic os = 1'b0;
    logic [TEMP_W-1:0] adc = 12'hc91;
    logic [TEMP_W-1:0] lim_hi = 12'h7ff;
    logic [TEMP_W-1:0] temp;
    logic busy;
    logic hs;
    logic [7:0] st;
    logic [7:0] rx;
    int err_count = 0;
    int comparisons = 0;

    tsi_if lnk();
    tsi_dev #(.POR_LEN(POR), .TOUT_LEN(TOUT)) u_tsi_dev (.clk_sys(clk_sys),
        .srst(srst), .bus(lnk.dev), .addr_select_pin(strap),
        .conv_mode_hi_bit(mode[1]), .conv_mode_lo_bit(mode[0]),
        .comparator_interrupt_select(tm), .oneshot_req(os),
        .adc_code(adc), .limit_high(lim_hi), .limit_low(12'h800),
        .temp_value(temp), .conv_busy(busy), .hs_active(hs),
        .own_address(), .bus_ready());
    tsi_host #(.POR_LEN(POR)) u_tsi_host (.clk_sys(clk_sys), .srst(srst),
        .bus(lnk.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    tsi_link_properties #(.POR_LEN(POR), .TOUT_LEN(TOUT)) u_props (
        .clk_sys(clk_sys), .srst(srst), .scl(lnk.scl), .sda(lnk.sda),
        .sda_dev_oe(lnk.sda_dev_oe), .alert_oe(lnk.alert_oe));

    // 20 MHz system clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle register strobes
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Bus operation, then poll busy with a bound; hang left to watchdog
    task automatic op(input logic [7:0] c, input logic [7:0] tx);
        wr_reg(HR_TXD, tx);
        wr_reg(HR_CMD, c);
        repeat (1000) begin
            rd_reg(HR_STAT, st);
            if (st[0] === 1'b0) break;
        end
        rd_reg(HR_RXD, rx);
    endtask : op
    task automatic probe(input logic [7:0] a, input logic [7:0] exp);
        op(8'h00, 8'h00);
        op(8'h01, a);
        chk(st, exp);
        op(8'h03, 8'h00);
    endtask : probe
    task automatic gc(input logic [7:0] c);
        op(8'h00, 8'h00);
        op(8'h01, GC_BYTE);
        op(8'h01, c);
        chk(st, 8'h08);
        op(8'h03, 8'h00);
    endtask : gc
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog, well past the expected run of about 1.2 ms
    initial begin
        #5ms;
        err_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        rd_reg(HR_STAT, st);
        chk(st, 8'h00);
        rd_reg(4'h2, st);
        chk(st, 8'h00);
        repeat (POR + 10) @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            strap <= k[1:0];
            gc(GC_LATCH);
            probe({ADDR_BASE, k[1:0], 1'b0}, 8'h08);
        end
        strap <= 2'h1;
        probe({ADDR_BASE, 2'h3, 1'b0}, 8'h08);
        probe({ADDR_BASE, 2'h1, 1'b0}, 8'h0a);
        $display("address test done");
        op(8'h00, 8'h00);
        op(8'h01, 8'h0b);
        chk(st, 8'h0a);
        chk({7'h0, hs}, 8'h01);
        op(8'h03, 8'h00);
        chk({7'h0, hs}, 8'h00);
        $display("fast code test done");
        op(8'h00, 8'h00);
        op(8'h01, {ADDR_BASE, 2'h3, 1'b1});
        op(8'h06, 8'h00);
        chk(rx, 8'hc9);
        adc <= 12'h123;
        op(8'h02, 8'h00);
        chk(rx, 8'h10);
        op(8'h03, 8'h00);
        repeat (4200) @(posedge clk_sys);
        chk(temp[11:4], 8'h12);
        chk({temp[3:0], 4'h0}, 8'h30);
        $display("temperature test done");
        mode <= 2'h1;
        repeat (2100) @(posedge clk_sys);
        tm <= 1'b1;
        lim_hi <= 12'h100;
        os <= 1'b1;
        @(posedge clk_sys);
        os <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({7'h0, busy}, 8'h01);
        repeat (2100) @(posedge clk_sys);
        chk({7'h0, busy}, 8'h00);
        rd_reg(HR_STAT, st);
        chk(st, 8'h0c);
        op(8'h00, 8'h00);
        op(8'h01, ARA_BYTE);
        chk(st, 8'h0c);
        op(8'h02, 8'h00);
        chk(rx, {ADDR_BASE, 2'h3, 1'b1});
        op(8'h03, 8'h00);
        chk(st, 8'h08);
        probe(ARA_BYTE, 8'h0a);
        $display("alert test done");
        gc(GC_RESET);
        chk(temp[11:4], 8'h00);
        op(8'h00, 8'h00);
        op(8'h01, {ADDR_BASE, 2'h1, 1'b1});
        chk(st, 8'h08);
        repeat (TOUT + 60) @(posedge clk_sys);
        chk({7'h0, lnk.sda_dev_oe}, 8'h00);
        op(8'h03, 8'h00);
        probe({ADDR_BASE, 2'h1, 1'b0}, 8'h08);
        $display("reset and timeout test done");
        finish_test();
    end
endmodule : tb_temp_sensor_i2c_target
`default_nettype wire
